// ### src/sctl_pkg.sv
package sctl_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] TIMER0_CONTROL_IDX = 8'hD2;
  localparam logic [7:0] SYSTEM_MODE_IDX = 8'hDF;
  localparam logic [7:0] STOP_UNLOCK_IDX = 8'hE4;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'hF8;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hF9;
  // Word-aligned byte addresses derived from the indices.
  localparam logic [9:0] TIMER0_CONTROL_ADDR = {TIMER0_CONTROL_IDX, 2'b00};
  localparam logic [9:0] SYSTEM_MODE_ADDR = {SYSTEM_MODE_IDX, 2'b00};
  localparam logic [9:0] STOP_UNLOCK_ADDR = {STOP_UNLOCK_IDX, 2'b00};
  localparam logic [9:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  // Field positions of the system mode register.
  localparam int MODE_GIE_BIT = 3;
  localparam int MODE_PAGE_LSB = 0;
  localparam int MODE_PAGE_W = 3;
  // Field positions of the timer 0 control register.
  localparam int T0_SEL_LSB = 6;
  localparam int T0_CLR_BIT = 3;
  localparam int T0_IE_BIT = 1;
  localparam int T0_PEND_BIT = 0;
  // Reset values.
  localparam logic [7:0] STOP_UNLOCK_RST = 8'h00;
  localparam logic [1:0] T0_SEL_RST = 2'h0;
  localparam logic [2:0] PAGE_RST = 3'h0;
  // Value that unlocks the stop instruction.
  localparam logic [7:0] STOP_KEY = 8'hA5;
  // Shared interrupt vector and the reset address.
  localparam logic [15:0] INT_VECTOR = 16'h0000;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  // Prescaler terminal counts, each the divide ratio less one.
  localparam int PRESC_W = 12;
  localparam logic [11:0] DIV4096_LAST = 12'hFFF;
  localparam logic [11:0] DIV256_LAST = 12'h0FF;
  localparam logic [11:0] DIV8_LAST = 12'h007;
  localparam logic [11:0] DIV1_LAST = 12'h000;
  // Interrupt status layout.
  localparam int IRQ_W = 2;
  localparam int IRQ_T0_MATCH = 0;
  localparam int IRQ_STOP_REFUSED = 1;

  // Instruction strobes from the CPU core, one-cycle pulses.
  typedef struct packed {
    logic irq_on;
    logic irq_off;
    logic irq_return;
    logic int_ack;
    logic stop_exec;
  } sctl_cpu_ops_t;
endpackage

// ### src/sctl_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Stop allowed only when unlock holds A5
// - Locked stop loads PC with reset address
// - Mode bit 3 is global interrupt enable
// - Mode bits 2..0 select page, zero used
// - Timer clock divided by 4096,256,8,1
// - Writing 1 to bit 3 clears counter
// - Pending bit reads set, write 0 clears
// - All interrupts share vector 0000H
// - Request needs global and source enable
// - Enable instruction sets, disable clears enable
// - Acknowledge clears enable, return sets it
module sctl_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sctl_pkg::sctl_cpu_ops_t cpu_ops,
  input wire logic t0_match,
  output logic stop_enter,
  output logic pc_load,
  output logic [15:0] pc_load_addr,
  output logic int_req,
  output logic [15:0] int_vector,
  output logic [2:0] page_sel,
  output logic t0_tick,
  output logic t0_clear,
  output logic irq
);

  // The decode needs the ten low address bits at least.
  if (ADDR_W < 10) begin : g_bad_addr_w
    $error("ADDR_W must be at least 10.");
  end

  // Stored register fields.
  logic [7:0] stop_unlock_reg;
  logic gie_reg;
  logic [2:0] page_reg;
  logic [1:0] t0_sel_reg;
  logic t0_clr_bit_reg;
  logic t0_ie_reg;
  logic t0_pend_reg;
  logic [sctl_pkg::IRQ_W-1:0] irq_status_reg;
  logic [sctl_pkg::IRQ_W-1:0] irq_mask_reg;
  // Prescaler count and its terminal value.
  logic [11:0] presc_reg;
  logic [11:0] presc_last;
  // Registered outputs.
  logic [31:0] prdata_reg;
  logic stop_enter_reg;
  logic pc_load_reg;
  logic t0_tick_reg;
  logic t0_clear_reg;
  // Bus decode terms.
  logic upper_zero;
  logic hit_t0;
  logic hit_mode;
  logic hit_stop;
  logic hit_ists;
  logic hit_imsk;
  logic hit_any;
  logic wr_acc;
  logic wr_lane0;
  logic [7:0] rd_byte;
  // Stop instruction outcome terms.
  logic stop_ok;
  logic stop_refused;
  logic [sctl_pkg::IRQ_W-1:0] irq_events;

  // Upper address bits beyond the register window must be zero for a hit.
  if (ADDR_W > 10) begin : g_upper
    assign upper_zero = (paddr[ADDR_W-1:10] == '0);
  end else begin : g_no_upper
    assign upper_zero = 1'b1;
  end

  // Address decode of the five registers.
  assign hit_t0 = upper_zero && (paddr[9:0] == sctl_pkg::TIMER0_CONTROL_ADDR);
  assign hit_mode = upper_zero && (paddr[9:0] == sctl_pkg::SYSTEM_MODE_ADDR);
  assign hit_stop = upper_zero && (paddr[9:0] == sctl_pkg::STOP_UNLOCK_ADDR);
  assign hit_ists = upper_zero && (paddr[9:0] == sctl_pkg::IRQ_STATUS_ADDR);
  assign hit_imsk = upper_zero && (paddr[9:0] == sctl_pkg::IRQ_MASK_ADDR);
  assign hit_any = hit_t0 || hit_mode || hit_stop || hit_ists || hit_imsk;
  // A write takes effect only in the access phase, with byte lane 0 enabled.
  assign wr_acc = psel && penable && pwrite && hit_any;
  assign wr_lane0 = wr_acc && pstrb[0];

  // The slave never stalls; unmapped addresses answer with an error.
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_reg;

  // Read multiplexer; unused bits read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_t0) begin
      rd_byte[sctl_pkg::T0_SEL_LSB +: 2] = t0_sel_reg;
      rd_byte[sctl_pkg::T0_CLR_BIT] = t0_clr_bit_reg;
      rd_byte[sctl_pkg::T0_IE_BIT] = t0_ie_reg;
      rd_byte[sctl_pkg::T0_PEND_BIT] = t0_pend_reg;
    end else if (hit_mode) begin
      rd_byte[sctl_pkg::MODE_GIE_BIT] = gie_reg;
      rd_byte[sctl_pkg::MODE_PAGE_LSB +: sctl_pkg::MODE_PAGE_W] = page_reg;
    end else if (hit_stop) begin
      rd_byte = stop_unlock_reg;
    end else if (hit_ists) begin
      rd_byte[sctl_pkg::IRQ_W-1:0] = irq_status_reg;
    end else if (hit_imsk) begin
      rd_byte[sctl_pkg::IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // Stop unlock register, plain read and write.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stop_unlock_reg <= sctl_pkg::STOP_UNLOCK_RST;
    end else if (wr_lane0 && hit_stop) begin
      stop_unlock_reg <= pwdata[7:0];
    end
  end

  assign stop_ok = cpu_ops.stop_exec && (stop_unlock_reg == sctl_pkg::STOP_KEY);
  assign stop_refused = cpu_ops.stop_exec && (stop_unlock_reg != sctl_pkg::STOP_KEY);

  // Stop outcome pulses: enter stop mode, or jump to the reset address.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stop_enter_reg <= 1'b0;
      pc_load_reg <= 1'b0;
    end else begin
      stop_enter_reg <= stop_ok;
      pc_load_reg <= stop_refused;
    end
  end
  assign stop_enter = stop_enter_reg;
  assign pc_load = pc_load_reg;
  assign pc_load_addr = sctl_pkg::RESET_ADDR;

  // Global interrupt enable; instruction events take priority over bus writes.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gie_reg <= 1'b0;
    end else if (cpu_ops.int_ack) begin
      gie_reg <= 1'b0;
    end else if (cpu_ops.irq_off) begin
      gie_reg <= 1'b0;
    end else if (cpu_ops.irq_on || cpu_ops.irq_return) begin
      gie_reg <= 1'b1;
    end else if (wr_lane0 && hit_mode) begin
      gie_reg <= pwdata[sctl_pkg::MODE_GIE_BIT];
    end
  end

  // Page select, stored as written; only page 0 has registers behind it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      page_reg <= sctl_pkg::PAGE_RST;
    end else if (wr_lane0 && hit_mode) begin
      page_reg <= pwdata[sctl_pkg::MODE_PAGE_LSB +: sctl_pkg::MODE_PAGE_W];
    end
  end
  assign page_sel = page_reg;

  // Timer 0 control fields; the clear bit keeps whatever was written.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t0_sel_reg <= sctl_pkg::T0_SEL_RST;
      t0_clr_bit_reg <= 1'b0;
      t0_ie_reg <= 1'b0;
    end else if (wr_lane0 && hit_t0) begin
      t0_sel_reg <= pwdata[sctl_pkg::T0_SEL_LSB +: 2];
      t0_clr_bit_reg <= pwdata[sctl_pkg::T0_CLR_BIT];
      t0_ie_reg <= pwdata[sctl_pkg::T0_IE_BIT];
    end
  end

  // Counter clear pulse on each write of a one to the clear bit.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t0_clear_reg <= 1'b0;
    end else begin
      t0_clear_reg <= wr_lane0 && hit_t0 && pwdata[sctl_pkg::T0_CLR_BIT];
    end
  end
  assign t0_clear = t0_clear_reg;

  // Match pending flag; a match in the clearing cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t0_pend_reg <= 1'b0;
    end else if (t0_match) begin
      t0_pend_reg <= 1'b1;
    end else if (wr_lane0 && hit_t0 && !pwdata[sctl_pkg::T0_PEND_BIT]) begin
      t0_pend_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (t0_sel_reg)
      2'b00: presc_last = sctl_pkg::DIV4096_LAST;
      2'b01: presc_last = sctl_pkg::DIV256_LAST;
      2'b10: presc_last = sctl_pkg::DIV8_LAST;
      2'b11: presc_last = sctl_pkg::DIV1_LAST;
    endcase
  end

  // Prescaler; a counter clear also restarts it so the first period is whole.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presc_reg <= 12'h000;
      t0_tick_reg <= 1'b0;
    end else if (t0_clear_reg) begin
      presc_reg <= 12'h000;
      t0_tick_reg <= 1'b0;
    end else if (presc_reg >= presc_last) begin
      presc_reg <= 12'h000;
      t0_tick_reg <= 1'b1;
    end else begin
      presc_reg <= presc_reg + 12'h001;
      t0_tick_reg <= 1'b0;
    end
  end
  assign t0_tick = t0_tick_reg;

  assign int_req = gie_reg && t0_ie_reg && t0_pend_reg;
  assign int_vector = sctl_pkg::INT_VECTOR;

  // Events seen by the sticky status register.
  assign irq_events = {stop_refused, t0_match};

  // Sticky status, cleared by writing ones; a new event wins over the clear.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else if (wr_lane0 && hit_ists) begin
      irq_status_reg <= (irq_status_reg & ~pwdata[sctl_pkg::IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  // Mask register of the same layout as the status.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (wr_lane0 && hit_imsk) begin
      irq_mask_reg <= pwdata[sctl_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Unlocked stop enters stop mode only.
  property p_stop_ok;
    @(posedge mclk) disable iff (!rst_n)
    (cpu_ops.stop_exec && stop_unlock_reg == 8'hA5) |=> (stop_enter && !pc_load);
  endproperty
  a_stop_ok: assert property (p_stop_ok) else $error("Unlocked stop did not enter stop.");
  // Locked stop jumps to the reset address.
  property p_stop_bad;
    @(posedge mclk) disable iff (!rst_n)
    (cpu_ops.stop_exec && stop_unlock_reg != 8'hA5) |=> (pc_load && !stop_enter && pc_load_addr == 16'h0000);
  endproperty
  a_stop_bad: assert property (p_stop_bad) else $error("Locked stop did not reload PC.");
  // No request while the global enable is clear.
  property p_gie_gate;
    @(posedge mclk) disable iff (!rst_n)
    !gie_reg |-> !int_req;
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("Request with global enable clear.");
  // Page field follows a mode write.
  property p_page;
    @(posedge mclk) disable iff (!rst_n)
    (wr_lane0 && hit_mode) |=> (page_sel == $past(pwdata[2:0]));
  endproperty
  a_page: assert property (p_page) else $error("Page select not stored.");
  // Divide by 8 gives a tick every eighth cycle.
  property p_div8;
    @(posedge mclk) disable iff (!rst_n)
    (t0_tick && t0_sel_reg == 2'b10 && !t0_clear_reg) ##1 (t0_sel_reg == 2'b10 && !t0_clear_reg)[*7] |=> t0_tick;
  endproperty
  a_div8: assert property (p_div8) else $error("Divide by 8 period wrong.");
  // A one written to the clear bit pulses clear and is kept.
  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
    (wr_lane0 && hit_t0 && pwdata[3]) |=> (t0_clear && t0_clr_bit_reg) ##1 (!t0_clear);
  endproperty
  a_clear: assert property (p_clear) else $error("Counter clear misbehaved.");
  // Pending holds unless a zero is written to it.
  property p_pend;
    @(posedge mclk) disable iff (!rst_n)
    (t0_match || (t0_pend_reg && !(wr_lane0 && hit_t0 && !pwdata[0]))) |=> t0_pend_reg;
  endproperty
  a_pend: assert property (p_pend) else $error("Pending flag lost.");
  // Any request uses the shared vector.
  property p_vector;
    @(posedge mclk) disable iff (!rst_n)
    int_req |-> (int_vector == 16'h0000);
  endproperty
  a_vector: assert property (p_vector) else $error("Wrong interrupt vector.");
  // A match with both gates open and left untouched raises a request on the next cycle.
  property p_two_gates;
    @(posedge mclk) disable iff (!rst_n)
    (t0_match && gie_reg && t0_ie_reg && !cpu_ops.int_ack && !cpu_ops.irq_off && !(wr_lane0 && (hit_t0 || hit_mode)))
      |=> int_req;
  endproperty
  a_two_gates: assert property (p_two_gates) else $error("Open gates gave no request.");
  // The enable instruction, issued without disable or acknowledge, sets the enable on the next cycle.
  property p_on_off;
    @(posedge mclk) disable iff (!rst_n)
    (cpu_ops.irq_on && !cpu_ops.irq_off && !cpu_ops.int_ack) |=> gie_reg;
  endproperty
  a_on_off: assert property (p_on_off) else $error("Enable instruction ignored.");
  // A disabled source stays pending without requesting.
  property p_src_off;
    @(posedge mclk) disable iff (!rst_n)
    (t0_pend_reg && !t0_ie_reg) |-> !int_req;
  endproperty
  a_src_off: assert property (p_src_off) else $error("Disabled source requested.");
  // Acknowledge clears the enable until a return, an enable instruction or a mode write sets it again.
  property p_ack;
    @(posedge mclk) disable iff (!rst_n)
    cpu_ops.int_ack |=> (!gie_reg && !int_req);
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge left enable set.");

endmodule
`default_nettype wire

// ### test/sctl_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural CPU core: issues instruction strobes and timer match events.
module sctl_cpu_model (
  input wire logic mclk,
  input wire logic int_req,
  output var sctl_pkg::sctl_cpu_ops_t cpu_ops,
  output var logic t0_match
);
  // Strobes idle low so nothing is issued during reset.
  initial begin
    cpu_ops = '0;
    t0_match = 1'b0;
  end
  // Raises one strobe bit for exactly one cycle, changed just after rising edges.
  task automatic op(input int idx);
    @(posedge mclk);
    cpu_ops[idx] <= 1'b1;
    @(posedge mclk);
    cpu_ops <= '0;
  endtask
  // One-cycle timer match event.
  task automatic match();
    @(posedge mclk);
    t0_match <= 1'b1;
    @(posedge mclk);
    t0_match <= 1'b0;
  endtask
  // Acknowledges a request once it is seen, or anyway after a bounded wait of 50 cycles.
  task automatic ack_when_req();
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    op(1);
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the system control register bank.
module tb;
  localparam int OP_STOP = 0;
  localparam int OP_ACK = 1;
  localparam int OP_RETURN = 2;
  localparam int OP_OFF = 3;
  localparam int OP_ON = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, stop_enter, pc_load, int_req, t0_tick, t0_clear, irq, t0_match;
  logic [15:0] pc_load_addr, int_vector;
  logic [2:0] page_sel;
  sctl_pkg::sctl_cpu_ops_t cpu_ops;
  int n_mismatch = 0;
  int checks_done = 0;
  // Clock of 4 ns.
  always #2 mclk = ~mclk;
  sctl_regs i_sctl_regs (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_ops(cpu_ops), .t0_match(t0_match), .stop_enter(stop_enter), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .int_req(int_req), .int_vector(int_vector), .page_sel(page_sel),
    .t0_tick(t0_tick), .t0_clear(t0_clear), .irq(irq));
  sctl_cpu_model i_sctl_cpu_model (.mclk(mclk), .int_req(int_req), .cpu_ops(cpu_ops), .t0_match(t0_match));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints counts and verdict, then stops.
  task automatic end_sim();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] rd,
    output logic er);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, a};
    pwdata <= {24'h0, d};
    pstrb <= 4'hF;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    n = 0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    // A slave that never answers counts as a mismatch.
    if (n >= 50) begin
      n_mismatch++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, exp);
  endtask
  // Reset values, unmapped access and page field.
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdc(sctl_pkg::STOP_UNLOCK_ADDR, 32'h0);
    rdc(sctl_pkg::SYSTEM_MODE_ADDR, 32'h0);
    rdc(sctl_pkg::TIMER0_CONTROL_ADDR, 32'h0);
    apb(1'b0, 10'h3F0, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    wr(sctl_pkg::SYSTEM_MODE_ADDR, 8'h05);
    @(negedge mclk);
    chk({29'h0, page_sel}, 32'h5);
    wr(sctl_pkg::SYSTEM_MODE_ADDR, 8'h00);
    @(negedge mclk);
    chk({29'h0, page_sel}, 32'h0);
  endtask
  // Stop with several unlock values, only the key enters stop mode.
  task automatic t_stop();
    logic [7:0] keys [4] = '{8'h00, 8'hA4, 8'h5A, 8'hA5};
    logic ok;
    for (int i = 0; i < 4; i++) begin
      ok = (keys[i] == 8'b10100101);
      wr(sctl_pkg::STOP_UNLOCK_ADDR, keys[i]);
      i_sctl_cpu_model.op(OP_STOP);
      @(negedge mclk);
      chk({31'h0, stop_enter}, {31'h0, ok});
      chk({31'h0, pc_load}, {31'h0, !ok});
      chk({16'h0, pc_load_addr}, 32'h0000);
      @(negedge mclk);
      chk({31'h0, pc_load | stop_enter}, 32'h0);
      rdc(sctl_pkg::IRQ_STATUS_ADDR, {30'h0, !ok, 1'b0});
      wr(sctl_pkg::IRQ_STATUS_ADDR, 8'h02);
    end
  endtask
  // Global enable by instructions, acknowledge and return.
  task automatic t_gie();
    int ops [4] = '{OP_ON, OP_OFF, OP_RETURN, OP_ACK};
    for (int i = 0; i < 4; i++) begin
      i_sctl_cpu_model.op(ops[i]);
      rdc(sctl_pkg::SYSTEM_MODE_ADDR, (i % 2 == 0) ? 32'h8 : 32'h0);
    end
  endtask
  // Each prescaler code gives its tick period; clear bit pulses and is kept.
  task automatic t_timer();
    int divs [4] = '{4096, 256, 8, 1};
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(sctl_pkg::TIMER0_CONTROL_ADDR, {s[1:0], 6'b001000});
      @(negedge mclk);
      chk({31'h0, t0_clear}, 32'h1);
      rdc(sctl_pkg::TIMER0_CONTROL_ADDR, {24'h0, s[1:0], 6'b001000});
      @(negedge mclk);
      n = 0;
      while (t0_tick !== 1'b1 && n < 5000) begin
        @(negedge mclk);
        n++;
      end
      @(negedge mclk);
      n = 1;
      while (t0_tick !== 1'b1 && n < 5000) begin
        @(negedge mclk);
        n++;
      end
      chk(n, divs[s]);
    end
    wr(sctl_pkg::TIMER0_CONTROL_ADDR, 8'hC0);
    @(negedge mclk);
    chk({31'h0, t0_clear}, 32'h0);
  endtask
  // Pending flag, two-gate request, status and mask, then a service routine.
  task automatic t_irq();
    wr(sctl_pkg::TIMER0_CONTROL_ADDR, 8'h00);
    i_sctl_cpu_model.op(OP_ON);
    i_sctl_cpu_model.match();
    rdc(sctl_pkg::TIMER0_CONTROL_ADDR, 32'h1);
    chk({31'h0, int_req}, 32'h0);
    wr(sctl_pkg::TIMER0_CONTROL_ADDR, 8'h03);
    @(negedge mclk);
    chk({31'h0, int_req}, 32'h1);
    chk({16'h0, int_vector}, 32'h0000);
    i_sctl_cpu_model.op(OP_OFF);
    @(negedge mclk);
    chk({31'h0, int_req}, 32'h0);
    rdc(sctl_pkg::IRQ_STATUS_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(sctl_pkg::IRQ_MASK_ADDR, 8'h01);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(sctl_pkg::IRQ_STATUS_ADDR, 8'h01);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    i_sctl_cpu_model.op(OP_ON);
    @(negedge mclk);
    chk({31'h0, int_req}, 32'h1);
    i_sctl_cpu_model.ack_when_req();
    @(negedge mclk);
    chk({31'h0, int_req}, 32'h0);
    // Service routine clears the pending flag before returning.
    wr(sctl_pkg::TIMER0_CONTROL_ADDR, 8'h02);
    rdc(sctl_pkg::TIMER0_CONTROL_ADDR, 32'h2);
    i_sctl_cpu_model.op(OP_RETURN);
    rdc(sctl_pkg::SYSTEM_MODE_ADDR, 32'h8);
    chk({31'h0, int_req}, 32'h0);
  endtask
  // Main sequence: reset for three cycles, then the scenarios.
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_stop();
    t_gie();
    t_timer();
    t_irq();
    end_sim();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
